// ---- pkg/spr_pkg.sv ----
// constants for the per-port receive snapshot and transmit overhead insert register slice
package spr_pkg;
	localparam int SPR_PORTS = 4;
	localparam int SPR_NSNAP = 11;
	localparam logic [11:0] SPR_PORT_STRIDE = 12'h400;
	// offsets within one port's copy
	localparam logic [9:0] SPR_OFF_UNIT_SEL = 10'h2D4;
	localparam logic [9:0] SPR_OFF_SAMPLE_CMD = 10'h2D8;
	localparam logic [9:0] SPR_OFF_SNAP_BASE = 10'h2E8;
	localparam logic [9:0] SPR_OFF_LINE_REI = 10'h2E8;
	localparam logic [9:0] SPR_OFF_PATH_REI = 10'h2EC;
	localparam logic [9:0] SPR_OFF_POS_JUST = 10'h2F0;
	localparam logic [9:0] SPR_OFF_NEG_JUST = 10'h2F4;
	localparam logic [9:0] SPR_OFF_RX_VALID = 10'h2F8;
	localparam logic [9:0] SPR_OFF_IDLE_ABORT = 10'h2FC;
	localparam logic [9:0] SPR_OFF_CORR_ADDR = 10'h300;
	localparam logic [9:0] SPR_OFF_DROP_CHECK = 10'h304;
	localparam logic [9:0] SPR_OFF_OVERFLOW = 10'h308;
	localparam logic [9:0] SPR_OFF_SHORT_PKT = 10'h30C;
	localparam logic [9:0] SPR_OFF_LONG_PKT = 10'h310;
	localparam logic [9:0] SPR_OFF_TX_J0 = 10'h320;
	localparam logic [9:0] SPR_OFF_TX_E1F1 = 10'h324;
	localparam logic [9:0] SPR_OFF_TX_DCC = 10'h328;
	localparam logic [9:0] SPR_OFF_TX_K12 = 10'h32C;
	// snapshot index k is line REI (0) .. long packet (10); its command bit is k + this
	localparam int SPR_CMD_BIT_BASE = 3;
	localparam int SPR_IDX_POS_JUST = 2;
	localparam int SPR_IDX_NEG_JUST = 3;
	localparam int SPR_UNIT_PATH_REI_BIT = 4;
	localparam int SPR_UNIT_RX_VALID_BIT = 5;
	localparam logic [13:0] SPR_CMD_MASK = 14'h3FF8;
	// reset values
	localparam logic [31:0] SPR_RST_SNAP = 32'h0000_0000;
	localparam logic [7:0] SPR_RST_J0 = 8'h01;
	localparam logic [23:0] SPR_RST_BYTES = 24'h00_0000;
	// coding forced into K2 bits 6 to 8 while line alarms are sent
	localparam logic [2:0] SPR_K2_AIS_CODE = 3'h7;
	localparam logic [2:0] SPR_K2_RDI_CODE = 3'h6;
endpackage

// ---- verilog/spr_regs.sv ----
// per-port receive counter snapshots and transmit overhead insert registers, four ports
//
// Notes on behaviour
// - path REI snapshot is 32-bit read-only; unit follows the path REI unit select
// - positive justification snapshot in bits 15-0, upper bits read zero
// - negative justification snapshot in bits 15-0, upper bits read zero
// - cell mode: valid cell count read from the 32-bit receive valid snapshot
// - packet mode: same snapshot holds packets or bytes per the count-unit bit
// - idle cells or aborted packets share one 32-bit read-only snapshot
// - header-corrected cells or address/control error packets share one 32-bit snapshot
// - header-drop cells or frame check error packets share one 32-bit snapshot
// - receive overflow dropped cells or packets go to a 32-bit read-only snapshot
// - short packet count captured as 32-bit read-only value
// - long packet count captured as 32-bit read-only value
// - section trace byte bits 7-0 sent in J0, resets to 01
// - low byte sent as E1, second byte as F1, both reset zero
// - D1, D2, D3 inserted from bits 7-0, 15-8, 23-16
// - K1 from bits 7-0, K2 from bits 15-8
// - line AIS or RDI overrides transmitted K2 bits 6 to 8
// - without line alarms the programmed K2 goes out unchanged
// - writing 1 to a sample bit copies live counter then hardware clears bit
// - path REI unit bit selects bits (0) or frames (1); resets to bits
`timescale 1ns/1ps
`default_nettype none
module spr_regs
	import spr_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// synchronous microprocessor port, byte address
	input wire logic i_cs,
	input wire logic i_wr,
	input wire logic [11:0] i_addr,
	input wire logic [31:0] i_wdata,
	output logic [31:0] o_rdata,
	output logic o_ack,
	// live counters from the counter engines, same clock
	input wire logic [SPR_PORTS-1:0][SPR_NSNAP-1:0][31:0] i_live_count,
	input wire logic [SPR_PORTS-1:0] i_line_ais_tx,
	input wire logic [SPR_PORTS-1:0] i_line_rdi_tx,
	output logic [SPR_PORTS-1:0] o_path_rei_unit_frames,
	output logic [SPR_PORTS-1:0] o_rx_valid_unit_bytes,
	output logic [SPR_PORTS-1:0][7:0] o_tx_j0,
	output logic [SPR_PORTS-1:0][7:0] o_tx_e1,
	output logic [SPR_PORTS-1:0][7:0] o_tx_f1,
	output logic [SPR_PORTS-1:0][7:0] o_tx_d1,
	output logic [SPR_PORTS-1:0][7:0] o_tx_d2,
	output logic [SPR_PORTS-1:0][7:0] o_tx_d3,
	output logic [SPR_PORTS-1:0][7:0] o_tx_k1,
	output logic [SPR_PORTS-1:0][7:0] o_tx_k2
);
	logic [9:0] off;
	logic [1:0] port_sel;
	logic [SPR_PORTS-1:0][31:0] port_rdata;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic ack_d;
	logic ack_q;

	assign off = i_addr[9:0];
	assign port_sel = i_addr[11:10];

	genvar p;
	generate
		for (p = 0; p < SPR_PORTS; p++) begin : g_port
			logic wr_en;
			logic [10:0] cmd_d;
			logic [10:0] cmd_q;
			logic [1:0] unit_d;
			logic [1:0] unit_q;
			logic [SPR_NSNAP-1:0][31:0] snap_d;
			logic [SPR_NSNAP-1:0][31:0] snap_q;
			logic [7:0] j0_d;
			logic [7:0] j0_q;
			logic [15:0] e1f1_d;
			logic [15:0] e1f1_q;
			logic [23:0] dcc_d;
			logic [23:0] dcc_q;
			logic [15:0] k12_d;
			logic [15:0] k12_q;
			logic [7:0] k2_out_d;
			logic [7:0] k2_out_q;
			logic [31:0] rd_word;

			assign wr_en = i_cs && i_wr && (port_sel == p[1:0]);

			always_comb begin
				cmd_d = cmd_q;
				unit_d = unit_q;
				snap_d = snap_q;
				j0_d = j0_q;
				e1f1_d = e1f1_q;
				dcc_d = dcc_q;
				k12_d = k12_q;
				// a pending bit is served and cleared together on the next edge
				for (int k = 0; k < SPR_NSNAP; k++) begin
					if (cmd_q[k]) begin
						snap_d[k] = i_live_count[p][k];
						cmd_d[k] = 1'b0;
					end
				end
				// justification snapshots are 16 bits wide
				snap_d[SPR_IDX_POS_JUST][31:16] = 16'h0000;
				snap_d[SPR_IDX_NEG_JUST][31:16] = 16'h0000;
				if (wr_en) begin
					unique case (off)
						SPR_OFF_UNIT_SEL: begin
							unit_d = {i_wdata[SPR_UNIT_RX_VALID_BIT], i_wdata[SPR_UNIT_PATH_REI_BIT]};
						end
						SPR_OFF_SAMPLE_CMD: begin
							// a new request wins over the clear of a completing one
							cmd_d = cmd_d | i_wdata[SPR_CMD_BIT_BASE +: SPR_NSNAP];
						end
						SPR_OFF_TX_J0: begin
							j0_d = i_wdata[7:0];
						end
						SPR_OFF_TX_E1F1: begin
							e1f1_d = i_wdata[15:0];
						end
						SPR_OFF_TX_DCC: begin
							dcc_d = i_wdata[23:0];
						end
						SPR_OFF_TX_K12: begin
							k12_d = i_wdata[15:0];
						end
						default: begin
						end
					endcase
				end
				// alarm coding sits in K2 bits 6-8, the three low-order bits of the byte
				k2_out_d = k12_q[15:8];
				if (i_line_ais_tx[p]) begin
					k2_out_d[2:0] = SPR_K2_AIS_CODE;
				end else if (i_line_rdi_tx[p]) begin
					k2_out_d[2:0] = SPR_K2_RDI_CODE;
				end
			end

			always_ff @(posedge i_sys_clk or posedge i_rst) begin
				if (i_rst) begin
					cmd_q <= 11'h000;
					unit_q <= 2'h0;
					for (int k = 0; k < SPR_NSNAP; k++) begin
						snap_q[k] <= SPR_RST_SNAP;
					end
					j0_q <= SPR_RST_J0;
					e1f1_q <= SPR_RST_BYTES[15:0];
					dcc_q <= SPR_RST_BYTES;
					k12_q <= SPR_RST_BYTES[15:0];
					k2_out_q <= SPR_RST_BYTES[7:0];
				end else begin
					cmd_q <= cmd_d;
					unit_q <= unit_d;
					snap_q <= snap_d;
					j0_q <= j0_d;
					e1f1_q <= e1f1_d;
					dcc_q <= dcc_d;
					k12_q <= k12_d;
					k2_out_q <= k2_out_d;
				end
			end

			// read mux; no register changes on a read
			always_comb begin
				rd_word = 32'h0000_0000;
				unique case (off)
					SPR_OFF_UNIT_SEL: begin
						rd_word[SPR_UNIT_PATH_REI_BIT] = unit_q[0];
						rd_word[SPR_UNIT_RX_VALID_BIT] = unit_q[1];
					end
					SPR_OFF_SAMPLE_CMD: begin
						rd_word[SPR_CMD_BIT_BASE +: SPR_NSNAP] = cmd_q;
					end
					SPR_OFF_LINE_REI, SPR_OFF_PATH_REI, SPR_OFF_POS_JUST, SPR_OFF_NEG_JUST,
					SPR_OFF_RX_VALID, SPR_OFF_IDLE_ABORT, SPR_OFF_CORR_ADDR, SPR_OFF_DROP_CHECK,
					SPR_OFF_OVERFLOW, SPR_OFF_SHORT_PKT, SPR_OFF_LONG_PKT: begin
						rd_word = snap_q[4'((off - SPR_OFF_SNAP_BASE) >> 2)];
					end
					SPR_OFF_TX_J0: begin
						rd_word[7:0] = j0_q;
					end
					SPR_OFF_TX_E1F1: begin
						rd_word[15:0] = e1f1_q;
					end
					SPR_OFF_TX_DCC: begin
						rd_word[23:0] = dcc_q;
					end
					SPR_OFF_TX_K12: begin
						rd_word[15:0] = k12_q;
					end
					default: begin
					end
				endcase
			end

			assign port_rdata[p] = rd_word;
			assign o_path_rei_unit_frames[p] = unit_q[0];
			assign o_rx_valid_unit_bytes[p] = unit_q[1];
			assign o_tx_j0[p] = j0_q;
			assign o_tx_e1[p] = e1f1_q[7:0];
			assign o_tx_f1[p] = e1f1_q[15:8];
			assign o_tx_d1[p] = dcc_q[7:0];
			assign o_tx_d2[p] = dcc_q[15:8];
			assign o_tx_d3[p] = dcc_q[23:16];
			assign o_tx_k1[p] = k12_q[7:0];
			assign o_tx_k2[p] = k2_out_q;
		end
	endgenerate

	// every access, mapped or not, is answered one cycle later; unmapped reads give zero
	always_comb begin
		ack_d = i_cs;
		rdata_d = rdata_q;
		if (i_cs && !i_wr) begin
			rdata_d = port_rdata[port_sel];
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	assign o_ack = ack_q;
	assign o_rdata = rdata_q;
endmodule // spr_regs
`default_nettype wire

// ---- testbench/spr_regs_sva.sv ----
// assertions on the register slice handshake and transmit overhead outputs
`timescale 1ns/1ps
`default_nettype none
module spr_regs_sva
	import spr_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_cs,
	input wire logic i_wr,
	input wire logic [11:0] i_addr,
	input wire logic [31:0] o_rdata,
	input wire logic o_ack,
	input wire logic [SPR_PORTS-1:0] i_line_ais_tx,
	input wire logic [SPR_PORTS-1:0] i_line_rdi_tx,
	input wire logic [SPR_PORTS-1:0][7:0] o_tx_j0,
	input wire logic [SPR_PORTS-1:0][7:0] o_tx_k2
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	chk_ack_on_access: assert property (i_cs |=> o_ack) else $error("no ack after access");
	chk_ack_when_idle: assert property (!i_cs |=> !o_ack) else $error("ack without access");
	chk_k2_ais_code: assert property (i_line_ais_tx[2] |=> o_tx_k2[2][2:0] == SPR_K2_AIS_CODE)
		else $error("k2 ais coding wrong");
	chk_k2_rdi_code: assert property (!i_line_ais_tx[2] && i_line_rdi_tx[2] |=> o_tx_k2[2][2:0] == 3'h6)
		else $error("k2 rdi coding wrong");
	chk_j0_reset_val: assert property ($fell(i_rst) |-> o_tx_j0 == {SPR_PORTS{8'h01}})
		else $error("j0 reset value wrong");
	chk_just_upper_zero: assert property (o_ack && $past(!i_wr && (i_addr[9:0] == 10'h2F0 ||
		i_addr[9:0] == 10'h2F4)) |-> o_rdata[31:16] == 16'h0000) else $error("justification upper bits set");
	chk_rdata_read_only: assert property (!$stable(o_rdata) |-> $past(i_cs && !i_wr))
		else $error("read data moved without a read");
	chk_k2_alarm_hold: assert property ((i_line_ais_tx[2] || i_line_rdi_tx[2]) [*2] |-> o_tx_k2[2][2] == 1'b1)
		else $error("k2 alarm bit dropped");
	cover property (i_cs && i_wr && i_addr[9:0] == SPR_OFF_SAMPLE_CMD);
	cover property (i_line_ais_tx[2] && i_line_rdi_tx[2]);
	cover property (o_ack && $past(!i_wr && i_addr[9:0] == SPR_OFF_NEG_JUST));
endmodule // spr_regs_sva
bind spr_regs spr_regs_sva u_sva (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cs(i_cs), .i_wr(i_wr), .i_addr(i_addr),
	.o_rdata(o_rdata), .o_ack(o_ack), .i_line_ais_tx(i_line_ais_tx), .i_line_rdi_tx(i_line_rdi_tx),
	.o_tx_j0(o_tx_j0), .o_tx_k2(o_tx_k2));
`default_nettype wire

// ---- testbench/spr_regs_tb.sv ----
// self-checking bench for the snapshot and overhead insert register slice
`timescale 1ns/1ps
`default_nettype none
module spr_regs_tb
	import spr_pkg::*;
;
	logic clk = 0, rst = 1, cs = 0, wr = 0, ack;
	logic [11:0] addr = 0;
	logic [31:0] wd = 0, rd_v, rdata;
	logic [3:0] ais = 0, rdi = 0, pu, vu;
	logic [SPR_PORTS-1:0][SPR_NSNAP-1:0][31:0] live = '0;
	logic [3:0][7:0] j0, e1, f1, d1, d2, d3, k1, k2;
	int n_errors = 0, checked = 0;
	spr_regs u_dut (.i_sys_clk(clk), .i_rst(rst), .i_cs(cs), .i_wr(wr), .i_addr(addr), .i_wdata(wd),
		.o_rdata(rdata), .o_ack(ack), .i_live_count(live), .i_line_ais_tx(ais), .i_line_rdi_tx(rdi),
		.o_path_rei_unit_frames(pu), .o_rx_valid_unit_bytes(vu), .o_tx_j0(j0), .o_tx_e1(e1), .o_tx_f1(f1),
		.o_tx_d1(d1), .o_tx_d2(d2), .o_tx_d3(d3), .o_tx_k1(k1), .o_tx_k2(k2));
	always #2 clk = ~clk;
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one access per call; ack and read data are taken in the answer cycle
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(negedge clk);
		cs = 1; wr = w; addr = a; wd = d;
		@(negedge clk);
		cs = 0;
		rd_v = rdata;
		chk("ack", 32'h1, {31'h0, ack});
	endtask
	task rchk(input logic [11:0] a, input logic [31:0] e);
		bus(0, a, 32'h0);
		chk($sformatf("reg %h", a), e, rd_v);
	endtask
	task summarize;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task t_reset;
		for (int p = 0; p < 4; p++) begin
			rchk({p[1:0], SPR_OFF_TX_J0}, 32'h1);
			rchk({p[1:0], SPR_OFF_TX_K12}, 32'h0);
			chk("j0", 32'h1, {24'h0, j0[p]});
		end
		chk("units", 32'h0, {24'h0, pu, vu});
		rchk(12'h31C, 32'h0);
	endtask
	task t_snap;
		logic [31:0] v;
		for (int p = 0; p < 4; p++) begin
			for (int k = 0; k < 11; k++) live[p][k] = {4'hA, p[3:0], k[7:0], 16'hC35A ^ k[15:0]};
			bus(1, {p[1:0], SPR_OFF_SAMPLE_CMD}, {18'h0, SPR_CMD_MASK});
			rchk({p[1:0], SPR_OFF_SAMPLE_CMD}, 32'h0);
			live[p] = ~live[p];
			bus(1, {p[1:0], SPR_OFF_PATH_REI}, 32'h0);
			for (int k = 1; k < 11; k++) begin
				v = ~live[p][k];
				if (k == 2 || k == 3) v[31:16] = 16'h0000;
				rchk({p[1:0], SPR_OFF_SNAP_BASE + {k[7:0], 2'b00}}, v);
			end
		end
	endtask
	task t_tx;
		bus(1, 12'hB20, 32'hFFFF_FF3C);
		bus(1, 12'hB24, 32'hFFFF_1E2D);
		bus(1, 12'hB28, 32'hFF96_8778);
		bus(1, 12'hB2C, 32'hFFFF_A55A);
		repeat (2) @(negedge clk);
		chk("j0", 32'h3C, {24'h0, j0[2]});
		chk("e1f1", 32'h1E2D, {16'h0, f1[2], e1[2]});
		chk("dcc", 32'h96_8778, {8'h0, d3[2], d2[2], d1[2]});
		chk("k12", 32'hA55A, {16'h0, k2[2], k1[2]});
		rchk(12'hB28, 32'h0096_8778);
		for (int m = 1; m < 4; m++) begin
			ais[2] = m[0];
			rdi[2] = m[1];
			repeat (2) @(negedge clk);
			chk("k2", {24'h0, 5'h14, m[0] ? 3'h7 : 3'h6}, {24'h0, k2[2]});
		end
		ais[2] = 0;
		rdi[2] = 0;
		repeat (2) @(negedge clk);
		chk("k2", 32'hA5, {24'h0, k2[2]});
	endtask
	task t_unit;
		bus(1, 12'h6D4, 32'hFFFF_FFFF);
		@(negedge clk);
		chk("units", 32'h3, {30'h0, vu[1], pu[1]});
		rchk(12'h6D4, 32'h30);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst = 0;
		t_reset;
		t_snap;
		t_tx;
		t_unit;
		summarize;
	end
	initial begin
		#40000;
		n_errors++;
		summarize;
	end
endmodule // spr_regs_tb
`default_nettype wire
